// ### common/can_tx_pkg.sv
// package: register map, field layout and types of the transmit abort block
// assumes a 32-bit apb slave, one aligned word per register
package can_tx_pkg;
    localparam int           num_buf        = 3;
    localparam logic [11:0]  off_abort_req  = 12'h008;
    localparam logic [11:0]  off_abort_ack  = 12'h00c;
    localparam logic [11:0]  off_buf_sel    = 12'h010;
    localparam logic [11:0]  off_tx_empty   = 12'h014;
    localparam logic [11:0]  off_tx_ie      = 12'h018;
    localparam logic [11:0]  off_init_ctl   = 12'h01c;
    localparam logic [11:0]  off_win_base   = 12'h040;
    localparam logic [11:0]  off_win_end    = 12'h07f;
    localparam logic [2:0]   rst_abort_req  = 3'h0;
    localparam logic [2:0]   rst_abort_ack  = 3'h0;
    localparam logic [2:0]   rst_buf_sel    = 3'h0;
    localparam logic [2:0]   rst_tx_empty   = 3'h7;
    localparam logic [2:0]   rst_tx_ie      = 3'h0;
    localparam int           init_req_bit   = 0;
    localparam int           init_ack_bit   = 1;
    localparam int           win_words      = 16;

    // engine handshake for one buffer at a time
    typedef struct packed {
        logic       start;
        logic [1:0] idx;
    } tx_req_t;

    typedef struct packed {
        logic       done_ok;
        logic       done_fail;
    } tx_rsp_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;
endpackage

// ### core/tx_window_mem.sv
// small buffer store behind the transmit register window
// assumes one access per cycle; read data registered
`timescale 1ns/1ps
module tx_window_mem #(
    parameter int bufs  = 3,
    parameter int words = 16
) (
    // clock
    input  wire logic                             clk,
    // access
    input  wire logic                             we,
    input  wire logic [$clog2(bufs*words)-1:0]    addr,
    input  wire logic [31:0]                      wdata,
    output logic      [31:0]                      rdata
);
    logic [31:0] mem [bufs*words];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// ### core/lowest_one.sv
// lowest set bit of a vector, one-hot or zero
// assumes pure combinational use
`timescale 1ns/1ps
module lowest_one #(
    parameter int w = 3
) (
    // vector
    input  wire logic [w-1:0] vin,
    output logic      [w-1:0] vout
);
    logic [w-1:0] below;

    generate
        for (genvar i = 0; i < w; i++) begin : g_bit
            if (i == 0) begin : g_first
                assign below[i] = 1'b0;
            end else begin : g_rest
                assign below[i] = below[i-1] | vin[i-1];
            end
            assign vout[i] = vin[i] & ~below[i];
        end
    endgenerate
endmodule

// ### core/can_tx_abort.sv
// transmit abort request/acknowledge and buffer selection with apb access
// assumes an external protocol engine drives tx_rsp for the buffer it started
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
//Contract
//- software may request abort of any scheduled buffer, 1 means pending
//- grant abort only before start or after a failed attempt
//- abort sets empty flag and acknowledge; interrupt if enabled
//- software cannot clear request; cleared when empty flag sets
//- request register upper bits zero, reset zero, held in init
//- acknowledge reads 1 when last message aborted, read-only; a write in the cycle of an abort grant drops that acknowledge
//- acknowledge clears when software clears the empty flag
//- acknowledge held in reset while init mode active
//- lowest selected bit picks buffer mapped in window
//- select read-back shows only the lowest set bit
//- window access blocked while selected buffer is scheduled
//- window access refused when nothing selected
//- select held in init, writable only outside init
//- software clears empty flag to schedule; success sets it again
module can_tx_abort
    import can_tx_pkg::*;
#(
    parameter int bufs = num_buf
) (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // protocol engine
    output logic             tx_start,
    output logic      [1:0]  tx_idx,
    input  wire logic        tx_done_ok,
    input  wire logic        tx_done_fail,
    // interrupt
    output logic             tx_irq
);
    initial begin
        if (bufs != 3) begin
            $error("only three transmit buffers supported");
        end
    end

    typedef struct packed {
        logic [2:0] abort_req;
        logic [2:0] abort_ack;
        logic [2:0] buf_sel;
        logic [2:0] tx_empty;
        logic [2:0] tx_ie;
        logic [1:0] init;
        logic       busy;
        logic [1:0] cur;
        logic       win_rd;
        apb_rsp_t   rsp;
        tx_req_t    req;
        logic       irq;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [2:0]  sel_low;
    logic [2:0]  empty_set;
    logic [2:0]  empty_clr;
    logic [1:0]  sel_idx;
    logic        in_init;
    logic        no_init;
    logic        setup;
    logic        wr;
    logic        rd;
    logic        win_hit;
    logic        win_ok;
    logic [5:0]  mem_addr;
    logic [31:0] mem_rdata;
    logic [2:0]  pend;

    lowest_one #(.w(3)) u_low (
        .vin  (s_q.buf_sel),
        .vout (sel_low)
    );

    assign sel_idx = sel_low[0] ? 2'd0 : (sel_low[1] ? 2'd1 : 2'd2);
    assign in_init = s_q.init[init_req_bit] & s_q.init[init_ack_bit];
    assign no_init = ~s_q.init[init_req_bit] & ~s_q.init[init_ack_bit];
    assign setup   = psel & ~penable;
    assign wr      = setup & pwrite;
    assign rd      = setup & ~pwrite;
    assign win_hit = paddr >= off_win_base && paddr <= off_win_end;
    // window reachable only with a selected buffer that is not scheduled
    assign win_ok  = (|sel_low) & s_q.tx_empty[sel_idx];
    assign mem_addr = {sel_idx, paddr[5:2]};
    assign pend = s_q.abort_req & ~s_q.tx_empty;

    tx_window_mem #(.bufs(4), .words(win_words)) u_mem (
        .clk   (pclk),
        .we    (wr & win_hit & win_ok),
        .addr  (mem_addr),
        .wdata (pwdata),
        .rdata (mem_rdata)
    );

    always_comb begin
        s_d = s_q;
        empty_set = 3'h0;
        empty_clr = 3'h0;
        s_d.req.start = 1'b0;
        s_d.rsp.pready = 1'b0;
        s_d.rsp.pslverr = 1'b0;
        // engine outcome
        if (s_q.busy && tx_done_ok) begin
            empty_set[s_q.cur] = 1'b1;
            s_d.busy = 1'b0;
        end else if (s_q.busy && tx_done_fail) begin
            s_d.busy = 1'b0;
            if (s_q.abort_req[s_q.cur]) begin
                empty_set[s_q.cur] = 1'b1;
                s_d.abort_ack[s_q.cur] = 1'b1;
            end
        end
        // abort of buffers not in flight
        for (int i = 0; i < 3; i++) begin
            if (pend[i] && !(s_q.busy && s_q.cur == 2'(i))) begin
                empty_set[i] = 1'b1;
                s_d.abort_ack[i] = 1'b1;
            end
        end
        // start next scheduled buffer, lowest first
        if (!s_q.busy && !in_init) begin
            for (int i = 2; i >= 0; i--) begin
                if (!s_q.tx_empty[i] && !pend[i] && !empty_set[i]) begin
                    s_d.req.idx = 2'(i);
                end
            end
            if (|(~s_q.tx_empty & ~pend & ~empty_set)) begin
                s_d.req.start = 1'b1;
                s_d.busy = 1'b1;
                s_d.cur = s_d.req.idx;
            end
        end
        // register writes
        if (wr) begin
            s_d.rsp.pready = ~win_hit;
            unique case (paddr)
                off_abort_req: if (no_init) begin
                    s_d.abort_req = s_q.abort_req
                        | (pwdata[2:0] & ~s_q.tx_empty);
                end
                off_abort_ack: begin
                    // read-only: the write is taken, but drops any acknowledge granted in the same cycle
                    s_d.abort_ack = s_q.abort_ack;
                end
                off_buf_sel: if (no_init) begin
                    s_d.buf_sel = pwdata[2:0];
                end
                off_tx_empty: if (no_init) begin
                    empty_clr = pwdata[2:0];
                end
                off_tx_ie: if (no_init) begin
                    s_d.tx_ie = pwdata[2:0];
                end
                off_init_ctl: begin
                    s_d.init[init_req_bit] = pwdata[init_req_bit];
                end
                default: begin
                    s_d.rsp.pslverr = ~win_hit | ~win_ok;
                    s_d.rsp.pready = 1'b1;
                end
            endcase
        end
        if (rd) begin
            s_d.rsp.pready = ~(win_hit & win_ok);
            s_d.win_rd = win_hit & win_ok;
            unique case (paddr)
                off_abort_req: s_d.rsp.prdata = {29'h0, s_q.abort_req};
                off_abort_ack: s_d.rsp.prdata = {29'h0, s_q.abort_ack};
                off_buf_sel:   s_d.rsp.prdata = {29'h0, sel_low};
                off_tx_empty:  s_d.rsp.prdata = {29'h0, s_q.tx_empty};
                off_tx_ie:     s_d.rsp.prdata = {29'h0, s_q.tx_ie};
                off_init_ctl:  s_d.rsp.prdata = {30'h0, s_q.init};
                default: begin
                    s_d.rsp.prdata = 32'h0;
                    s_d.rsp.pslverr = ~win_hit | ~win_ok;
                end
            endcase
        end
        if (s_q.win_rd) begin
            s_d.win_rd = 1'b0;
            s_d.rsp.prdata = mem_rdata;
            s_d.rsp.pready = 1'b1;
        end
        // the running buffer cannot be rescheduled by software
        empty_clr = empty_clr & ~(s_q.busy ? (3'h1 << s_q.cur) : 3'h0);
        // set wins over a clear in the same cycle
        s_d.tx_empty = (s_q.tx_empty & ~empty_clr) | empty_set;
        s_d.abort_req = s_d.abort_req & ~empty_set;
        s_d.abort_ack = s_d.abort_ack & ~(empty_clr & ~empty_set);
        // init acknowledge follows request one cycle later
        s_d.init[init_ack_bit] = s_q.init[init_req_bit];
        if (in_init) begin
            s_d.abort_req = rst_abort_req;
            s_d.abort_ack = rst_abort_ack;
            s_d.buf_sel   = rst_buf_sel;
            s_d.tx_empty  = rst_tx_empty;
            s_d.tx_ie     = rst_tx_ie;
            s_d.busy      = 1'b0;
        end
        s_d.irq = |(s_d.tx_empty & s_d.tx_ie);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{abort_req: rst_abort_req, abort_ack: rst_abort_ack,
                     buf_sel: rst_buf_sel, tx_empty: rst_tx_empty,
                     tx_ie: rst_tx_ie, init: 2'h0, busy: 1'b0,
                     cur: 2'h0, win_rd: 1'b0, rsp: '0, req: '0,
                     irq: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata   = s_q.rsp.prdata;
    assign pready   = s_q.rsp.pready;
    assign pslverr  = s_q.rsp.pslverr;
    assign tx_start = s_q.req.start;
    assign tx_idx   = s_q.req.idx;
    assign tx_irq   = s_q.irq;

    a_req_no_clear: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(s_q.abort_req[0]) |-> s_q.tx_empty[0] || in_init ||
        $past(in_init)) else $error("abort request dropped");
    a_ack_sets_empty: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s_q.abort_ack[1]) |-> $rose(s_q.tx_empty[1]))
        else $error("ack without empty");
    a_ack_clears: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(s_q.tx_empty[2]) |-> !s_q.abort_ack[2])
        else $error("ack kept on schedule");
    a_init_hold: assert property (@(posedge pclk) disable iff (!presetn)
        in_init |=> s_q.abort_req == 3'h0 && s_q.abort_ack == 3'h0 &&
        s_q.buf_sel == 3'h0) else $error("init not holding");
    a_sel_onehot: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(sel_low) && (sel_low == (s_q.buf_sel & -s_q.buf_sel)))
        else $error("select read-back wrong");
    a_win_blocked: assert property (@(posedge pclk) disable iff (!presetn)
        rd && win_hit && !win_ok |=> pready && pslverr)
        else $error("window not refused");
    a_no_abort_busy: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.busy && !tx_done_fail && !in_init |=>
        !$rose(s_q.abort_ack[s_q.cur])) else $error("abort mid frame");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 tx_irq == $past(|(s_d.tx_empty & s_d.tx_ie)))
        else $error("irq mismatch");
    a_req_sched_only: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s_q.abort_req[0]) |-> !$past(s_q.tx_empty[0]))
        else $error("abort request on empty buffer");
    a_req_off_empty: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.abort_req & s_q.tx_empty) == 3'h0)
        else $error("abort request kept on empty buffer");
    a_ack_needs_empty: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.abort_ack & ~s_q.tx_empty) == 3'h0)
        else $error("ack on scheduled buffer");
    a_start_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        tx_start |=> !tx_start)
        else $error("start longer than one cycle");
    a_start_sched: assert property (@(posedge pclk) disable iff (!presetn)
        tx_start |-> !s_q.tx_empty[tx_idx])
        else $error("start of empty buffer");
    a_sel_init_lock: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == off_buf_sel && !no_init |=> $stable(s_q.buf_sel))
        else $error("select written in init");
    a_win_wr_blocked: assert property (@(posedge pclk) disable iff (!presetn)
        wr && win_hit && !win_ok |=> pready && pslverr)
        else $error("window write not refused");
    c_init_mode: cover property (@(posedge pclk) in_init);
    c_failed_abort: cover property (@(posedge pclk)
        s_q.busy && tx_done_fail && s_q.abort_req[s_q.cur]);
    c_abort_done: cover property (@(posedge pclk) $rose(s_q.abort_ack[0]));
    c_tx_ok: cover property (@(posedge pclk) s_q.busy && tx_done_ok);
    c_win_read: cover property (@(posedge pclk) s_q.win_rd);
endmodule

// ### bench/can_tx_abort_and_buffer_select_test.sv
// testbench: apb register sequences for abort, acknowledge and selection
// assumes the engine side is played by the bench through the done pulses
`timescale 1ns/1ps
module can_tx_abort_and_buffer_select_test
    import can_tx_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, tx_start, tx_done_ok, tx_done_fail;
    logic        tx_irq;
    logic [1:0]  tx_idx, st_idx;
    int          n_errors, compares, n_starts, s, o;

    can_tx_abort dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_start(tx_start), .tx_idx(tx_idx),
        .tx_done_ok(tx_done_ok), .tx_done_fail(tx_done_fail),
        .tx_irq(tx_irq));

    initial pclk = 1'b0;
    always #4 pclk = ~pclk;

    // counts engine starts
    always @(posedge pclk) begin
        if (tx_start === 1'b1) begin
            n_starts <= n_starts + 1;
            st_idx   <= tx_idx;
        end
    end

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; read data compared only on reads without error
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic e);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            final_report();
        end
        chk($sformatf("pslverr at %h", a), {31'h0, e}, {31'h0, pslverr});
        if (!w && !e) chk($sformatf("read at %h", a), d, prdata);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_start(input int cnt);
        int i;
        for (i = 0; i < 50 && n_starts != cnt; i++) @(posedge pclk);
        if (i == 50) begin
            n_errors++;
            final_report();
        end
    endtask

    task automatic pulse(input logic ok);
        @(posedge pclk);
        tx_done_ok   <= ok;
        tx_done_fail <= !ok;
        @(posedge pclk);
        tx_done_ok   <= 1'b0;
        tx_done_fail <= 1'b0;
    endtask

    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge pclk);
        chk("tx_irq", {31'h0, exp}, {31'h0, tx_irq});
    endtask

    initial begin
        {presetn, psel, penable, pwrite, tx_done_ok, tx_done_fail} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        n_starts = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        acc(0, off_abort_req, 32'h0, 0);
        acc(0, off_abort_ack, 32'h0, 0);
        acc(0, off_buf_sel, 32'h0, 0);
        acc(0, off_tx_empty, 32'h7, 0);
        acc(0, 12'h020, 32'h0, 1);
        $display("test reset done");
        acc(0, off_win_base, 32'h0, 1);
        acc(1, off_buf_sel, 32'h6, 0);
        acc(0, off_buf_sel, 32'h2, 0);
        acc(1, off_win_base + 12'h004, 32'ha5c3_0f12, 0);
        acc(0, off_win_base + 12'h004, 32'ha5c3_0f12, 0);
        $display("test select done");
        acc(1, off_tx_ie, 32'h2, 0);
        acc(1, off_tx_empty, 32'h2, 0);
        wait_start(1);
        chk("start index", 32'h1, {30'h0, st_idx});
        acc(0, off_win_base + 12'h004, 32'h0, 1);
        irq_chk(0);
        acc(1, off_abort_req, 32'hfb, 0);
        acc(0, off_abort_req, 32'h2, 0);
        acc(1, off_abort_req, 32'h0, 0);
        acc(0, off_abort_req, 32'h2, 0);
        acc(1, off_abort_ack, 32'h7, 0);
        acc(0, off_abort_ack, 32'h0, 0);
        pulse(0);
        acc(0, off_tx_empty, 32'h7, 0);
        acc(0, off_abort_ack, 32'h2, 0);
        acc(0, off_abort_req, 32'h0, 0);
        chk("retry starts", 32'h1, n_starts);
        irq_chk(1);
        acc(1, off_tx_ie, 32'h0, 0);
        irq_chk(0);
        acc(1, off_tx_ie, 32'h2, 0);
        acc(1, off_tx_empty, 32'h2, 0);
        acc(0, off_abort_ack, 32'h0, 0);
        irq_chk(0);
        wait_start(2);
        pulse(1);
        acc(0, off_tx_empty, 32'h7, 0);
        $display("test failed abort done");
        acc(1, off_tx_empty, 32'h1, 0);
        wait_start(3);
        acc(1, off_abort_req, 32'h1, 0);
        pulse(1);
        acc(0, off_abort_ack, 32'h0, 0);
        acc(0, off_abort_req, 32'h0, 0);
        acc(0, off_tx_empty, 32'h7, 0);
        $display("test late abort done");
        acc(1, off_tx_empty, 32'h5, 0);
        wait_start(4);
        s = int'(st_idx);
        o = (s == 0) ? 2 : 0;
        acc(1, off_abort_req, 32'h1 << o, 0);
        acc(0, off_abort_ack, 32'h1 << o, 0);
        acc(0, off_tx_empty, 32'h2 | (32'h1 << o), 0);
        pulse(1);
        acc(0, off_tx_empty, 32'h7, 0);
        $display("test early abort done");
        acc(1, off_init_ctl, 32'h1, 0);
        acc(0, off_init_ctl, 32'h3, 0);
        acc(0, off_abort_ack, 32'h0, 0);
        acc(0, off_buf_sel, 32'h0, 0);
        acc(1, off_buf_sel, 32'h1, 0);
        acc(0, off_buf_sel, 32'h0, 0);
        acc(1, off_init_ctl, 32'h0, 0);
        acc(0, off_init_ctl, 32'h0, 0);
        acc(1, off_buf_sel, 32'h5, 0);
        acc(0, off_buf_sel, 32'h1, 0);
        $display("test init done");
        final_report();
    end
endmodule
